// ### src/lwc_cfg.svh
`ifndef LWC_CFG_SVH
`define LWC_CFG_SVH

// register byte offsets
`define LWC_ADDR_W            8
`define LWC_OFS_CONTROL       8'h00
`define LWC_OFS_IRQ_STATUS    8'h04
`define LWC_OFS_IRQ_MASK      8'h08
`define LWC_OFS_STATE         8'h0C

// control register fields
`define LWC_CTRL_LINK_ACTIVE  0
`define LWC_CTRL_CONTENDER    1
`define LWC_CTRL_RESUME_EN    2
`define LWC_CTRL_RESET        3'h0

// interrupt status and mask fields
`define LWC_IRQ_PORT_EVENT    0
`define LWC_IRQ_CFG_TIMEOUT   1
`define LWC_IRQ_CABLE_POWER   2
`define LWC_IRQ_STATE_TIMEOUT 3
`define LWC_IRQ_RESET         4'h0

// state register fields
`define LWC_ST_STRAP          0
`define LWC_ST_WAKE           1
`define LWC_ST_LPS            2
`define LWC_ST_CABLE_POWER    3
`define LWC_ST_CABLE_INACTIVE 4
`define LWC_ST_CONTROL_LO     5

// timing: clock period, link clock period, wake period, power status filter
`define LWC_CLK_PERIOD_PS     5000
`define LWC_LINK_CLK_PS       20345
`define LWC_WAKE_PERIOD_NS    163
`define LWC_LINK_TICK_CYC     ((`LWC_LINK_CLK_PS) / (`LWC_CLK_PERIOD_PS))
`define LWC_WAKE_HALF_TICKS   4
`define LWC_LPS_LOW_NS        2600
`define LWC_LPS_LOW_CYC       (((`LWC_LPS_LOW_NS) * 1000 + (`LWC_CLK_PERIOD_PS) - 1) / (`LWC_CLK_PERIOD_PS))

`endif

// ### src/lwc_pkg.sv
package lwc_pkg;

	typedef struct packed {
		logic resume_port_irq_enable;
		logic contender;
		logic link_active_control_bit;
	} lwc_ctrl_type;

	typedef struct packed {
		logic state_timeout_irq_bit;
		logic cable_power_irq_bit;
		logic config_timeout_irq_bit;
		logic port_event_irq_bit;
	} lwc_irq_type;

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
	} lwc_ctl_drive_type;

	typedef enum logic [1:0] {
		WAKE_IDLE,
		WAKE_HIGH,
		WAKE_LOW
	} lwc_wake_state_type;

endpackage

// ### src/lwc_lps_filter.sv
`include "lwc_cfg.svh"

// power status filter: low must last past the threshold before it counts
module lwc_lps_filter (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic level_in,
	output logic      active
);
	localparam int unsigned LOW_CYC = `LWC_LPS_LOW_CYC;

	logic [9:0] low_count;

	// count consecutive low cycles, saturating at the threshold
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_count <= 10'h000;
		end else if (level_in) begin
			low_count <= 10'h000;
		end else if (low_count != LOW_CYC[9:0]) begin
			low_count <= low_count + 10'h001;
		end
	end

	// short glitches low still count as active
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			active <= 1'b0;
		end else if (level_in) begin
			active <= 1'b1;
		end else if (low_count == LOW_CYC[9:0]) begin
			active <= 1'b0;
		end
	end

endmodule

// ### src/lwc_top.sv
// Notes on behaviour
// - strap level during hardware reset sets default contender status, high means contender.
// - after reset the shared pin serves only as the link wake output.
// - active wake output is a square wave of about 163 ns, eight link clocks.
// - inactive wake output drives low; during hardware reset it floats.
// - wake may start only while link power status or link-active bit is off.
// - wake starts on addressed link-on packet or a set port-event bit.
// - wake starts on timeout or cable-power bits when resume enable is set.
// - wake runs until power status active and link-active bit set, or until the causing status bit is cleared.
// - bus reset stops a packet-only wake; interrupt-caused wake survives it.
// - pending interrupt while link active starts wake once link goes inactive.
// - cable inactive flag is high when no incoming bias is seen.
// - cable inactive flag is ignored until a hard reset has been done.
// - cable power comparator result is reported and feeds the cable-power interrupt.
// - both sides drive and read the two control lines, held when undriven.
// - power status counts inactive only after staying low past 2.6 us.
`include "lwc_cfg.svh"

module lwc_top (
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WR_DATA,
	input  wire logic        WR_STB,
	input  wire logic        RD_STB,
	output logic      [31:0] RD_DATA,
	output logic             IRQ,
	input  wire logic        CONTENDER_WAKE_PIN_IN,
	output logic             CONTENDER_WAKE_PIN_OUT,
	output logic             CONTENDER_WAKE_PIN_OE,
	input  wire logic        LINK_POWER_STATUS,
	input  wire logic        LINK_ON_PACKET,
	input  wire logic        BUS_RESET,
	input  wire logic        PORT_EVENT,
	input  wire logic        CONFIG_TIMEOUT,
	input  wire logic        STATE_TIMEOUT,
	input  wire logic        BIAS_DETECT,
	input  wire logic        CABLE_POWER_SENSE,
	output logic             CABLE_INACTIVE_FLAG,
	input  wire logic [1:0]  CTL_TX_DATA,
	input  wire logic        CTL_TX_EN,
	output logic      [1:0]  CTL_RX_DATA,
	input  wire logic [1:0]  PHY_LINK_CONTROL_IN,
	output logic      [1:0]  PHY_LINK_CONTROL_OUT,
	output logic      [1:0]  PHY_LINK_CONTROL_OE
);

	localparam int unsigned TICK_CYC = `LWC_LINK_TICK_CYC;
	localparam int unsigned HALF_TICKS = `LWC_WAKE_HALF_TICKS;

	lwc_pkg::lwc_ctrl_type       ctrl;
	lwc_pkg::lwc_irq_type        irq_status;
	lwc_pkg::lwc_irq_type        irq_mask;
	lwc_pkg::lwc_irq_type        irq_event;
	lwc_pkg::lwc_irq_type        irq_clear;
	lwc_pkg::lwc_ctl_drive_type  ctl_drive;
	lwc_pkg::lwc_wake_state_type wake_state;
	lwc_pkg::lwc_wake_state_type next_wake_state;
	logic                        reset_done;
	logic                        strap;
	logic                        lps_active;
	logic                        link_inactive;
	logic                        irq_cause;
	logic                        packet_pending;
	logic                        wake_request;
	logic                        cable_power;
	logic                        cable_power_seen;
	logic [2:0]                  tick_count;
	logic                        link_tick;
	logic [2:0]                  half_count;
	logic                        next_pin_out;
	logic [31:0]                 next_rd_data;
	logic                        wr_control;
	logic                        wr_status;
	logic                        wr_mask;

	////////////////////////////////////////////////////////////////////////////
	// reset release and strap capture

	// the strap is caught on the first edge after release; an async reset may
	// only load constants, so the pin cannot be sampled under reset itself
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			reset_done <= 1'b0;
			strap      <= 1'b0;
		end else if (!reset_done) begin
			reset_done <= 1'b1;
			strap      <= CONTENDER_WAKE_PIN_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register bus decode

	assign wr_control = WR_STB && (ADDR == `LWC_OFS_CONTROL);
	assign wr_status  = WR_STB && (ADDR == `LWC_OFS_IRQ_STATUS);
	assign wr_mask    = WR_STB && (ADDR == `LWC_OFS_IRQ_MASK);
	assign irq_clear  = wr_status ? lwc_pkg::lwc_irq_type'(WR_DATA[3:0]) : `LWC_IRQ_RESET;

	// control bits; contender defaults to the strap, software may overwrite it
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl <= `LWC_CTRL_RESET;
		end else if (!reset_done) begin
			ctrl.contender <= CONTENDER_WAKE_PIN_IN;
		end else if (wr_control) begin
			ctrl.link_active_control_bit <= WR_DATA[`LWC_CTRL_LINK_ACTIVE];
			ctrl.contender               <= WR_DATA[`LWC_CTRL_CONTENDER];
			ctrl.resume_port_irq_enable  <= WR_DATA[`LWC_CTRL_RESUME_EN];
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_mask <= `LWC_IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask <= lwc_pkg::lwc_irq_type'(WR_DATA[3:0]);
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		next_rd_data = 32'h0000_0000;
		case (ADDR)
			`LWC_OFS_CONTROL: begin
				next_rd_data[2:0] = ctrl;
			end
			`LWC_OFS_IRQ_STATUS: begin
				next_rd_data[3:0] = irq_status;
			end
			`LWC_OFS_IRQ_MASK: begin
				next_rd_data[3:0] = irq_mask;
			end
			`LWC_OFS_STATE: begin
				next_rd_data[`LWC_ST_STRAP]          = strap;
				next_rd_data[`LWC_ST_WAKE]           = wake_state != lwc_pkg::WAKE_IDLE;
				next_rd_data[`LWC_ST_LPS]            = lps_active;
				next_rd_data[`LWC_ST_CABLE_POWER]    = cable_power;
				next_rd_data[`LWC_ST_CABLE_INACTIVE] = CABLE_INACTIVE_FLAG;
				next_rd_data[`LWC_ST_CONTROL_LO +: 2] = CTL_RX_DATA;
			end
			default: begin
				next_rd_data = 32'h0000_0000;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RD_DATA <= 32'h0000_0000;
		end else begin
			RD_DATA <= RD_STB ? next_rd_data : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cable power and bias

	// comparator result is synchronous; a change after the first sample is an event
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cable_power      <= 1'b0;
			cable_power_seen <= 1'b0;
		end else begin
			cable_power      <= CABLE_POWER_SENSE;
			cable_power_seen <= 1'b1;
		end
	end

	// flag held low until a hard reset has completed, so no consumer sees junk
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CABLE_INACTIVE_FLAG <= 1'b0;
		end else if (reset_done) begin
			CABLE_INACTIVE_FLAG <= !BIAS_DETECT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, set wins over a write-one clear

	always_comb begin
		irq_event                        = `LWC_IRQ_RESET;
		irq_event.port_event_irq_bit     = PORT_EVENT;
		irq_event.config_timeout_irq_bit = CONFIG_TIMEOUT;
		irq_event.state_timeout_irq_bit  = STATE_TIMEOUT;
		irq_event.cable_power_irq_bit    = cable_power_seen && (cable_power != CABLE_POWER_SENSE);
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_status <= `LWC_IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_event;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(((irq_status & ~irq_clear) | irq_event) & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link power status filter

	lwc_lps_filter u_lps_filter (
		.clk      (REF_CLK),
		.reset_n  (RESET_N),
		.level_in (LINK_POWER_STATUS),
		.active   (lps_active)
	);

	////////////////////////////////////////////////////////////////////////////
	// wake decision

	assign link_inactive = !lps_active || !ctrl.link_active_control_bit;
	// interrupt cause is level based, so a pending bit wakes once link drops
	assign irq_cause = irq_status.port_event_irq_bit ||
		(ctrl.resume_port_irq_enable && (irq_status.config_timeout_irq_bit ||
		irq_status.cable_power_irq_bit || irq_status.state_timeout_irq_bit));

	// packet wake is remembered; a bus reset drops it unless a packet lands too
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			packet_pending <= 1'b0;
		end else if (LINK_ON_PACKET && link_inactive) begin
			packet_pending <= 1'b1;
		end else if (BUS_RESET || !link_inactive) begin
			packet_pending <= 1'b0;
		end
	end

	assign wake_request = reset_done && link_inactive && (irq_cause || packet_pending);

	////////////////////////////////////////////////////////////////////////////
	// link clock tick and square wave

	// divider stands in for the link clock, one tick per link clock period
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tick_count <= 3'h0;
			link_tick  <= 1'b0;
		end else if (tick_count == 3'(TICK_CYC - 1)) begin
			tick_count <= 3'h0;
			link_tick  <= 1'b1;
		end else begin
			tick_count <= tick_count + 3'h1;
			link_tick  <= 1'b0;
		end
	end

	always_comb begin
		next_wake_state = wake_state;
		case (wake_state)
			lwc_pkg::WAKE_IDLE: begin
				if (wake_request) begin
					next_wake_state = lwc_pkg::WAKE_HIGH;
				end
			end
			lwc_pkg::WAKE_HIGH: begin
				if (!wake_request) begin
					next_wake_state = lwc_pkg::WAKE_IDLE;
				end else if (link_tick && half_count == 3'(HALF_TICKS - 1)) begin
					next_wake_state = lwc_pkg::WAKE_LOW;
				end
			end
			lwc_pkg::WAKE_LOW: begin
				if (!wake_request) begin
					next_wake_state = lwc_pkg::WAKE_IDLE;
				end else if (link_tick && half_count == 3'(HALF_TICKS - 1)) begin
					next_wake_state = lwc_pkg::WAKE_HIGH;
				end
			end
			default: begin
				next_wake_state = lwc_pkg::WAKE_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wake_state <= lwc_pkg::WAKE_IDLE;
		end else begin
			wake_state <= next_wake_state;
		end
	end

	// ticks counted per half period; restarts whenever the half changes
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			half_count <= 3'h0;
		end else if (next_wake_state != wake_state) begin
			half_count <= 3'h0;
		end else if (link_tick) begin
			half_count <= half_count + 3'h1;
		end
	end

	assign next_pin_out = next_wake_state == lwc_pkg::WAKE_HIGH;

	// pin floats under reset so the strap resistor sets its level, then drives
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CONTENDER_WAKE_PIN_OE  <= 1'b0;
			CONTENDER_WAKE_PIN_OUT <= 1'b0;
		end else begin
			CONTENDER_WAKE_PIN_OE  <= reset_done;
			CONTENDER_WAKE_PIN_OUT <= reset_done && next_pin_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control lines to the link

	// with link power inactive the lines are held at zero; otherwise the core
	// drives when enabled and releases so the far side's holder keeps the level
	always_comb begin
		ctl_drive.out = CTL_TX_DATA;
		ctl_drive.oe  = {2{CTL_TX_EN}};
		if (!lps_active) begin
			ctl_drive.out = 2'h0;
			ctl_drive.oe  = 2'h3;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PHY_LINK_CONTROL_OUT <= 2'h0;
			PHY_LINK_CONTROL_OE  <= 2'h0;
		end else begin
			PHY_LINK_CONTROL_OUT <= ctl_drive.out;
			PHY_LINK_CONTROL_OE  <= ctl_drive.oe;
		end
	end

	// received level; when nobody drives, the line's holder keeps the last one
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CTL_RX_DATA <= 2'h0;
		end else begin
			CTL_RX_DATA <= PHY_LINK_CONTROL_IN;
		end
	end

endmodule

// ### bench/lwc_link_model.sv
module lwc_link_model (
	input  wire logic       clk,
	input  wire logic       power_on,
	input  wire logic       auto_wake,
	input  wire logic       strap,
	input  wire logic       pin_out,
	input  wire logic       pin_oe,
	input  wire logic [1:0] tx_data,
	input  wire logic       tx_en,
	input  wire logic [1:0] phy_out,
	input  wire logic [1:0] phy_oe,
	output logic            lps,
	output logic            pin,
	output logic      [1:0] ctl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] hold = 2'h0;
	logic [3:0] seen = 4'h0;
	logic       pin_d = 1'b0;
	// the strap resistor loses whenever the phy drives the pin
	assign pin = pin_oe ? pin_out : strap;
	// either end may drive; a released line keeps its last level
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ctl[i] = phy_oe[i] ? phy_out[i] : (tx_en ? tx_data[i] : hold[i]);
		end
	end
	always @(posedge clk) hold <= ctl;
	////////////////////////////////////////
	// slow answer: the link powers up only after four wake edges
	always @(posedge clk) begin
		pin_d <= pin;
		if (!auto_wake) seen <= 4'h0;
		else if (pin && !pin_d && seen != 4'hF) seen <= seen + 4'h1;
	end
	assign lps = power_on | (seen > 4'h3);
endmodule

// ### bench/lwc_top_properties.sv
module lwc_top_checker (
	input wire logic        REF_CLK,
	input wire logic        RESET_N,
	input wire logic        RD_STB,
	input wire logic [31:0] RD_DATA,
	input wire logic        CONTENDER_WAKE_PIN_OUT,
	input wire logic        CONTENDER_WAKE_PIN_OE,
	input wire logic        LINK_POWER_STATUS,
	input wire logic        PORT_EVENT,
	input wire logic        BIAS_DETECT,
	input wire logic        CABLE_INACTIVE_FLAG,
	input wire logic [1:0]  CTL_TX_DATA,
	input wire logic        CTL_TX_EN,
	input wire logic [1:0]  CTL_RX_DATA,
	input wire logic [1:0]  PHY_LINK_CONTROL_IN,
	input wire logic [1:0]  PHY_LINK_CONTROL_OUT,
	input wire logic [1:0]  PHY_LINK_CONTROL_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	logic [9:0] hi_run;
	logic [9:0] lo_run;
	logic [9:0] lo_lps;
	// lo_run and lo_lps saturate so a long idle never wraps into a short run; hi_run does not
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hi_run <= 10'h000;
			lo_run <= 10'h000;
			lo_lps <= 10'h000;
		end else begin
			hi_run <= CONTENDER_WAKE_PIN_OUT ? hi_run + 10'h001 : 10'h000;
			lo_run <= CONTENDER_WAKE_PIN_OUT ? 10'h000 : lo_run + {9'h000, lo_run != 10'h3FF};
			lo_lps <= LINK_POWER_STATUS ? 10'h000 : lo_lps + {9'h000, lo_lps != 10'h3FF};
		end
	end
	////////////////////////////////////////
	a_pin_driven: assert property ($past(RESET_N, 2) |-> CONTENDER_WAKE_PIN_OE)
		else $error("wake pin released after reset");
	a_high_max: assert property (hi_run <= 10'h013)
		else $error("wake high phase too long");
	a_low_half: assert property ($rose(CONTENDER_WAKE_PIN_OUT) && lo_run < 10'h028
		|-> lo_run >= 10'h00D && lo_run <= 10'h013)
		else $error("wake low phase wrong length");
	a_cable_flag: assert property ($past(RESET_N, 2)
		|-> CABLE_INACTIVE_FLAG == !$past(BIAS_DETECT))
		else $error("cable flag does not follow bias");
	a_ctl_sample: assert property ($past(RESET_N) |-> CTL_RX_DATA == $past(PHY_LINK_CONTROL_IN))
		else $error("control line sample wrong");
	a_ctl_follow: assert property ($past(RESET_N, 3) && $past(LINK_POWER_STATUS, 2)
		&& $past(LINK_POWER_STATUS, 3) |-> PHY_LINK_CONTROL_OUT == $past(CTL_TX_DATA)
		&& PHY_LINK_CONTROL_OE == {2{$past(CTL_TX_EN)}})
		else $error("control drive does not follow core");
	a_ctl_quiet: assert property (lo_lps > 10'h212
		|-> PHY_LINK_CONTROL_OUT == 2'h0 && PHY_LINK_CONTROL_OE == 2'h3)
		else $error("control lines not held low");
	a_wake_start: assert property (PORT_EVENT && lo_lps > 10'h212
		|-> ##[1:24] CONTENDER_WAKE_PIN_OUT)
		else $error("wake did not start");
	a_rd_only: assert property (!$past(RD_STB) |-> RD_DATA == 32'h0000_0000)
		else $error("read data outside its cycle");
	c_wave: cover property ($fell(CONTENDER_WAKE_PIN_OUT));
	c_event: cover property (PORT_EVENT && lo_lps > 10'h212);
	c_flag: cover property ($rose(CABLE_INACTIVE_FLAG));
endmodule

bind lwc_top lwc_top_checker u_lwc_top_checker (.REF_CLK, .RESET_N, .RD_STB, .RD_DATA,
	.CONTENDER_WAKE_PIN_OUT, .CONTENDER_WAKE_PIN_OE, .LINK_POWER_STATUS, .PORT_EVENT,
	.BIAS_DETECT, .CABLE_INACTIVE_FLAG, .CTL_TX_DATA, .CTL_TX_EN, .CTL_RX_DATA,
	.PHY_LINK_CONTROL_IN, .PHY_LINK_CONTROL_OUT, .PHY_LINK_CONTROL_OE);

// ### bench/lwc_top_tb_top.sv
module lwc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        REF_CLK = 1'b0, RESET_N = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
	logic [7:0]  ADDR = 8'h00;
	logic [31:0] WR_DATA = 32'h0, RD_DATA, e, m;
	logic        IRQ, CONTENDER_WAKE_PIN_IN, CONTENDER_WAKE_PIN_OUT, CONTENDER_WAKE_PIN_OE;
	logic        LINK_POWER_STATUS, CABLE_INACTIVE_FLAG, CTL_TX_EN = 1'b0, rd_wait = 1'b0;
	logic        LINK_ON_PACKET = 1'b0, BUS_RESET = 1'b0, PORT_EVENT = 1'b0;
	logic        CONFIG_TIMEOUT = 1'b0, STATE_TIMEOUT = 1'b0, CABLE_POWER_SENSE = 1'b0;
	logic        BIAS_DETECT = 1'b0, strap = 1'b1, pwr = 1'b0, auto = 1'b0, ltx_en = 1'b0;
	logic [1:0]  CTL_TX_DATA = 2'h0, ltx = 2'h0, CTL_RX_DATA, PHY_LINK_CONTROL_IN;
	logic [1:0]  PHY_LINK_CONTROL_OUT, PHY_LINK_CONTROL_OE;
	logic [31:0] exp_q[$], msk_q[$];
	logic [15:0] lfsr = 16'h9706;
	int          error_cnt = 0, checks_done = 0, cyc = 0;
	lwc_top u_lwc_top (.REF_CLK, .RESET_N, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA, .IRQ,
		.CONTENDER_WAKE_PIN_IN, .CONTENDER_WAKE_PIN_OUT, .CONTENDER_WAKE_PIN_OE,
		.LINK_POWER_STATUS, .LINK_ON_PACKET, .BUS_RESET, .PORT_EVENT, .CONFIG_TIMEOUT,
		.STATE_TIMEOUT, .BIAS_DETECT, .CABLE_POWER_SENSE, .CABLE_INACTIVE_FLAG, .CTL_TX_DATA,
		.CTL_TX_EN, .CTL_RX_DATA, .PHY_LINK_CONTROL_IN, .PHY_LINK_CONTROL_OUT,
		.PHY_LINK_CONTROL_OE);
	lwc_link_model u_lwc_link_model (.clk(REF_CLK), .power_on(pwr), .auto_wake(auto),
		.strap, .pin_out(CONTENDER_WAKE_PIN_OUT), .pin_oe(CONTENDER_WAKE_PIN_OE),
		.tx_data(ltx), .tx_en(ltx_en), .phy_out(PHY_LINK_CONTROL_OUT),
		.phy_oe(PHY_LINK_CONTROL_OE), .lps(LINK_POWER_STATUS), .pin(CONTENDER_WAKE_PIN_IN),
		.ctl(PHY_LINK_CONTROL_IN));
	initial forever #2.5 REF_CLK = ~REF_CLK;
	// the run needs about 1400 cycles; the ceiling leaves wide margin
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			give_verdict();
		end
	end
	////////////////////////////////////////
	function automatic logic [15:0] lfsr_next(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(string what, logic [31:0] ex, logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, ex, got);
		end
	endtask
	task automatic clk(int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		ADDR <= a;
		WR_DATA <= d;
		WR_STB <= 1'b1;
		clk(1);
		WR_STB <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] ex, logic [31:0] mk);
		ADDR <= a;
		RD_STB <= 1'b1;
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		clk(1);
		RD_STB <= 1'b0;
		clk(1);
	endtask
	// read data stand only in the cycle after the strobe
	always @(negedge REF_CLK) begin
		if (rd_wait) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk("rd_data", e & m, RD_DATA & m);
		end
		rd_wait = RD_STB;
	end
	task automatic pulse(int k);
		case (k)
			0: PORT_EVENT <= 1'b1;
			1: CONFIG_TIMEOUT <= 1'b1;
			2: CABLE_POWER_SENSE <= ~CABLE_POWER_SENSE;
			3: STATE_TIMEOUT <= 1'b1;
			4: LINK_ON_PACKET <= 1'b1;
			default: BUS_RESET <= 1'b1;
		endcase
		clk(1);
		{PORT_EVENT, CONFIG_TIMEOUT, STATE_TIMEOUT, LINK_ON_PACKET, BUS_RESET} <= 5'h00;
		clk(3);
	endtask
	task automatic wait_pin(logic v, output int n);
		n = 0;
		while (CONTENDER_WAKE_PIN_OUT !== v && n < 99) begin
			@(posedge REF_CLK);
			#1;
			n++;
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		int a;
		int b;
		for (int s = 1; s >= 0; s--) begin
			strap <= s[0];
			RESET_N <= 1'b0;
			clk(16);
			chk("pin_oe", 32'h0, CONTENDER_WAKE_PIN_OE);
			chk("flag", 32'h0, CABLE_INACTIVE_FLAG);
			RESET_N <= 1'b1;
			clk(3);
			rd(8'h00, {30'h0, s[0], 1'b0}, 32'hFFFF_FFFF);
			rd(8'h0C, {27'h0, 1'b1, 3'h0, s[0]}, 32'h7F);
		end
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0, 32'hFFFF_FFFF);
		$display("test reset done");
		wr(8'h08, 32'h1);
		pulse(0);
		chk("irq", 32'h1, IRQ);
		wait_pin(1'b1, a);
		wait_pin(1'b0, a);
		wait_pin(1'b1, b);
		wait_pin(1'b0, a);
		wait_pin(1'b1, b);
		chk("wake_high", 32'h10, a);
		chk("wake_low", 32'h10, b);
		wr(8'h08, 32'h0);
		clk(2);
		chk("irq_masked", 32'h0, IRQ);
		wr(8'h04, 32'h1);
		clk(2);
		chk("pin_idle", 32'h0, CONTENDER_WAKE_PIN_OUT);
		$display("test wake done");
		clk(60);
		pulse(4);
		rd(8'h0C, 32'h2, 32'h2);
		pulse(5);
		rd(8'h0C, 32'h0, 32'h2);
		clk(60);
		pulse(0);
		pulse(5);
		rd(8'h0C, 32'h2, 32'h2);
		wr(8'h04, 32'h1);
		clk(60);
		$display("test bus reset done");
		for (int k = 1; k < 4; k++) begin
			wr(8'h00, 32'h0);
			pulse(k);
			rd(8'h0C, 32'h0, 32'h2);
			wr(8'h00, 32'h4);
			clk(3);
			rd(8'h0C, 32'h2, 32'h2);
			wr(8'h04, 32'h1 << k);
			clk(60);
		end
		rd(8'h0C, 32'h8, 32'h8);
		$display("test resume done");
		pwr <= 1'b1;
		wr(8'h00, 32'h5);
		clk(3);
		pulse(0);
		rd(8'h0C, 32'h4, 32'h6);
		pwr <= 1'b0;
		clk(400);
		rd(8'h0C, 32'h4, 32'h6);
		clk(150);
		pulse(0);
		rd(8'h0C, 32'h2, 32'h6);
		auto <= 1'b1;
		clk(200);
		rd(8'h0C, 32'h4, 32'h6);
		wr(8'h04, 32'h1);
		$display("test link active done");
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			CTL_TX_DATA <= lfsr[1:0];
			CTL_TX_EN <= lfsr[2];
			ltx <= lfsr[4:3];
			ltx_en <= ~lfsr[2];
			BIAS_DETECT <= lfsr[5];
			clk(3);
			chk("ctl_rx", lfsr[2] ? lfsr[1:0] : lfsr[4:3], CTL_RX_DATA);
			chk("flag", !lfsr[5], CABLE_INACTIVE_FLAG);
			CTL_TX_EN <= 1'b0;
			ltx_en <= 1'b0;
			clk(3);
			chk("ctl_hold", lfsr[2] ? lfsr[1:0] : lfsr[4:3], CTL_RX_DATA);
		end
		$display("test control lines done");
		give_verdict();
	end
endmodule
